// file: rtl/pke_command_status.sv
// Chosen here: the APB register port and the address map.
`default_nettype none
// Function
// - Command bits 15:8 give operand length in 64-bit words for this operation.
// - Lengths from code 0x02 (128 bits) to 0x40 (4096 bits) are accepted.
// - Large multiplier build: 256 bits or 1024 multiples, no 256-bit exponent ops.
// - Bits 6:4 pick class 0 to 3; classes 4 to 7 are reserved.
// - Primitive codes 1-6 are valid, 8-A valid in prime field only, others reserved.
// - RSA/CRT/DSA class forces prime field; codes 0-A and C valid.
// - ECC codes 0-6 and 8-C valid; 7 reserved.
// - ECDSA class codes 0-5 valid; others reserved.
// - Launch bit sampled on rising edge starts the held command.
// - Launch while running is ignored; launch clears when operation ends.
// - Busy status bit 16 is high while processing, falls at finish.
// - Bit 12 reads 1 for composite, 0 for probable prime.
// - Bit 11 set when inversion code 6 or 9 finds no inverse.
// - Bit 10 updated by AB check, set when curve parameters invalid.
// - Bit 9 flags bad signature after ECDSA, DSA, Ed25519 validity checks.
// - Bit 7 flags bad order n; bit 6 flags pair not below prime.
// - Bit 5 flags point at infinity; bit 4 flags point off curve.
// - Bits 3:0 hold address of last failing point.
// - Bit 31 forces R^2 mod N recompute; engine clears it when done.
module pke_command_status #(
   parameter bit BIG_MULT = 1'b0
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic clockEnable,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic coreStart,
   output logic [6:0] coreOpcode,
   output logic coreField,
   output logic [7:0] coreSize,
   output logic coreRecalc,
   input wire logic coreDone,
   input wire logic coreR2Done,
   input wire logic coreComposite,
   input wire logic coreNoInverse,
   input wire logic coreAbBad,
   input wire logic coreSigBad,
   input wire logic coreNBad,
   input wire logic corePairBad,
   input wire logic coreInfinity,
   input wire logic coreOffCurve,
   input wire logic [3:0] coreFailAddr
);
   pke_pkg::pke_state_t state_reg;
   pke_pkg::pke_state_t state_next;
   logic [31:0] cmd_reg;
   logic [31:0] cmd_next;
   logic launch_reg;
   logic busy_reg;
   logic prime_reg;
   logic noInv_reg;
   logic abBad_reg;
   logic sigBad_reg;
   logic [7:0] flags_reg;
   logic [7:0] flags_next;
   logic [31:0] rdata_next;

   // Bus decode
   wire accessPhase = psel & penable;
   wire doWrite = accessPhase & pready & pwrite & clockEnable;
   wire hitCmd = paddr == pke_pkg::CMD_ADDR;
   wire hitLaunch = paddr == pke_pkg::LAUNCH_ADDR;
   wire hitStatus = paddr == pke_pkg::STATUS_ADDR;
   wire hitAny = hitCmd | hitLaunch | hitStatus;
   wire wrCmd = doWrite & hitCmd;
   wire wrLaunch = doWrite & hitLaunch & pwdata[pke_pkg::LAUNCH_BIT];
   wire wrStatus = doWrite & hitStatus;

   // Command fields of the held command
   wire [2:0] cls = cmd_reg[6:4];
   wire [3:0] low = cmd_reg[3:0];
   wire [7:0] opLen = cmd_reg[15:8];
   wire fieldBin = cmd_reg[pke_pkg::CMD_FIELD_BIT];

   // Operation code checks
   wire primOk = cls == pke_pkg::CLS_PRIM && low != 4'h0 &&
      low != 4'h7 && low <= pke_pkg::PRIM_LAST &&
      !(fieldBin && low >= pke_pkg::PRIM_MUL);
   wire rsaOk = cls == pke_pkg::CLS_RSA &&
      (low <= pke_pkg::RSA_LAST || low == pke_pkg::RSA_SRP);
   wire eccOk = cls == pke_pkg::CLS_ECC &&
      low != pke_pkg::ECC_RESERVED && low <= pke_pkg::ECC_LAST;
   wire ecdsaOk = cls == pke_pkg::CLS_ECDSA &&
      low <= pke_pkg::ECDSA_LAST;
   wire opOk = primOk | rsaOk | eccOk | ecdsaOk;

   // Operand length checks
   wire sizeInRange = opLen >= pke_pkg::SIZE_MIN &&
      opLen <= pke_pkg::SIZE_MAX;
   wire expOp = cls == pke_pkg::CLS_RSA || (cls == pke_pkg::CLS_ECC &&
      low >= pke_pkg::ECC_ED_FIRST);
   wire bigLenOk = opLen == pke_pkg::SIZE_256 ? !expOp :
      opLen[3:0] == 4'h0;
   wire sizeOk = sizeInRange && (!BIG_MULT || bigLenOk);
   wire cmdOk = opOk & sizeOk;

   // Launch accepted only from idle with a valid command
   wire isIdle = state_reg == pke_pkg::PKE_IDLE;
   wire isRun = state_reg == pke_pkg::PKE_RUN;
   wire launchNow = wrLaunch & isIdle & cmdOk;
   wire finish = isRun & coreDone;

   // Which status flags the finishing operation refreshes
   wire [3:0] runLow = coreOpcode[3:0];
   wire [2:0] runCls = coreOpcode[6:4];
   wire updPrime = runCls == pke_pkg::CLS_RSA &&
      runLow == pke_pkg::RSA_KEYGEN;
   wire updInv = runCls == pke_pkg::CLS_PRIM &&
      (runLow == pke_pkg::PRIM_INV_ODD ||
      runLow == pke_pkg::PRIM_INV_EVEN);
   wire updAb = runCls == pke_pkg::CLS_ECC &&
      runLow == pke_pkg::ECC_CHK_AB;
   wire updSig = (runCls == pke_pkg::CLS_ECDSA &&
      runLow <= pke_pkg::ECDSA_VERIFY) ||
      (runCls == pke_pkg::CLS_RSA && (runLow == pke_pkg::DSA_SIGN ||
      runLow == pke_pkg::DSA_VERIFY)) ||
      (runCls == pke_pkg::CLS_ECC &&
      runLow == pke_pkg::ECC_ED_VALID);
   wire updN = runCls == pke_pkg::CLS_ECC &&
      runLow == pke_pkg::ECC_CHK_N;
   wire updPair = runCls == pke_pkg::CLS_ECC &&
      runLow == pke_pkg::ECC_CHK_PAIR;
   wire updInf = runCls == pke_pkg::CLS_ECC ||
      runCls == pke_pkg::CLS_ECDSA;
   wire updOff = runCls == pke_pkg::CLS_ECC &&
      (runLow == pke_pkg::ECC_ON_CURVE ||
      runLow == pke_pkg::ECC_LAST);
   wire pointFail = (updN & coreNBad) | (updPair & corePairBad) |
      (updInf & coreInfinity) | (updOff & coreOffCurve);

   // Sequencer next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         pke_pkg::PKE_IDLE: begin
            if (launchNow) begin
               state_next = pke_pkg::PKE_RUN;
            end
         end
         pke_pkg::PKE_RUN: begin
            if (coreDone) begin
               state_next = pke_pkg::PKE_IDLE;
            end
         end
         default: begin
            state_next = pke_pkg::PKE_IDLE;
         end
      endcase
   end

   // Command write; software set of recalc wins over engine clear
   always_comb begin
      cmd_next = cmd_reg;
      if (coreR2Done) begin
         cmd_next[pke_pkg::CMD_RECALC_BIT] = 1'b0;
      end
      if (wrCmd) begin
         cmd_next = pwdata & pke_pkg::CMD_WR_MASK;
      end
   end

   // Low status byte: software write, finishing operation wins
   always_comb begin
      flags_next = flags_reg;
      if (wrStatus) begin
         flags_next = pwdata[7:0];
      end
      if (finish) begin
         if (updN) begin
            flags_next[7] = coreNBad;
         end
         if (updPair) begin
            flags_next[6] = corePairBad;
         end
         if (updInf) begin
            flags_next[5] = coreInfinity;
         end
         if (updOff) begin
            flags_next[4] = coreOffCurve;
         end
         if (pointFail) begin
            flags_next[3:0] = coreFailAddr;
         end
      end
   end

   // Read data selection
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (hitCmd) begin
         rdata_next = cmd_reg;
      end else if (hitLaunch) begin
         rdata_next[pke_pkg::LAUNCH_BIT] = launch_reg;
      end else if (hitStatus) begin
         rdata_next[pke_pkg::STAT_BUSY_BIT] = busy_reg;
         rdata_next[pke_pkg::STAT_PRIME_BIT] = prime_reg;
         rdata_next[pke_pkg::STAT_NOINV_BIT] = noInv_reg;
         rdata_next[pke_pkg::STAT_AB_BIT] = abBad_reg;
         rdata_next[pke_pkg::STAT_SIG_BIT] = sigBad_reg;
         rdata_next[7:0] = flags_reg;
      end
   end

   // APB answer: one wait state, error on unmapped address
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (clockEnable) begin
         pready <= accessPhase & !pready;
         pslverr <= accessPhase & !pready & !hitAny;
         prdata <= (accessPhase & !pwrite) ? rdata_next : 32'h0000_0000;
      end
   end

   // Command register and sequencer
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_reg <= pke_pkg::PKE_IDLE;
         cmd_reg <= pke_pkg::CMD_RESET;
      end else if (clockEnable) begin
         state_reg <= state_next;
         cmd_reg <= cmd_next;
      end
   end

   // Launch and busy bits, engine start pulse
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         launch_reg <= 1'b0;
         busy_reg <= 1'b0;
         coreStart <= 1'b0;
      end else if (clockEnable) begin
         coreStart <= launchNow;
         if (launchNow) begin
            launch_reg <= 1'b1;
            busy_reg <= 1'b1;
         end else if (finish) begin
            launch_reg <= 1'b0;
            busy_reg <= 1'b0;
         end
      end
   end

   // Command handed to the arithmetic core, held for the run
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         coreOpcode <= 7'h00;
         coreField <= 1'b0;
         coreSize <= 8'h00;
         coreRecalc <= 1'b0;
      end else if (clockEnable && launchNow) begin
         coreOpcode <= cmd_reg[6:0];
         coreField <= fieldBin & (cls != pke_pkg::CLS_RSA);
         coreSize <= opLen;
         coreRecalc <= cmd_reg[pke_pkg::CMD_RECALC_BIT];
      end
   end

   // Result flags
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         prime_reg <= 1'b0;
         noInv_reg <= 1'b0;
         abBad_reg <= 1'b0;
         sigBad_reg <= 1'b0;
         flags_reg <= pke_pkg::FLAGS_RESET;
      end else if (clockEnable) begin
         flags_reg <= flags_next;
         if (finish && updPrime) begin
            prime_reg <= coreComposite;
         end
         if (finish && updInv) begin
            noInv_reg <= coreNoInverse;
         end
         if (finish && updAb) begin
            abBad_reg <= coreAbBad;
         end
         if (finish && updSig) begin
            sigBad_reg <= coreSigBad;
         end
      end
   end

   // Checks
   chk_busy_launch: assert property (@(posedge clock)
      disable iff (reset) busy_reg == launch_reg)
      else $error("busy and launch bits disagree");

   chk_start_once: assert property (@(posedge clock)
      disable iff (reset) coreStart && clockEnable |-> busy_reg ##1
      (!coreStart || !clockEnable))
      else $error("start pulse without busy or repeated");

   chk_run_ignore: assert property (@(posedge clock)
      disable iff (reset) busy_reg && !coreDone && clockEnable |=>
      busy_reg && !coreStart)
      else $error("launch not ignored while running");

   chk_done_clear: assert property (@(posedge clock)
      disable iff (reset) busy_reg && coreDone && clockEnable |=>
      !launch_reg && !busy_reg)
      else $error("launch bit not cleared at finish");

   chk_size_legal: assert property (@(posedge clock)
      disable iff (reset) coreStart |-> coreSize >= pke_pkg::SIZE_MIN &&
      coreSize <= pke_pkg::SIZE_MAX)
      else $error("illegal operand length started");

   chk_class_legal: assert property (@(posedge clock)
      disable iff (reset) coreStart |-> !coreOpcode[6])
      else $error("reserved class started");

   chk_rsa_field: assert property (@(posedge clock)
      disable iff (reset) coreStart && coreOpcode[6:4] ==
      pke_pkg::CLS_RSA |-> !coreField)
      else $error("binary field passed to RSA class");

   chk_noinv_update: assert property (@(posedge clock)
      disable iff (reset) finish && updInv && clockEnable |=>
      noInv_reg == $past(coreNoInverse))
      else $error("no-inverse flag not updated");

   chk_ab_update: assert property (@(posedge clock)
      disable iff (reset) finish && updAb && clockEnable |=>
      abBad_reg == $past(coreAbBad))
      else $error("curve AB flag not updated");

   chk_recalc_clear: assert property (@(posedge clock)
      disable iff (reset) coreR2Done && !wrCmd && clockEnable |=>
      !cmd_reg[pke_pkg::CMD_RECALC_BIT])
      else $error("recalc bit not cleared");

   chk_prime_update: assert property (@(posedge clock)
      disable iff (reset) finish && updPrime && clockEnable |=>
      prime_reg == $past(coreComposite))
      else $error("primality flag not updated");

   chk_sig_update: assert property (@(posedge clock)
      disable iff (reset) finish && updSig && clockEnable |=>
      sigBad_reg == $past(coreSigBad))
      else $error("signature flag not updated");

   chk_inf_update: assert property (@(posedge clock)
      disable iff (reset) finish && updInf && clockEnable |=>
      flags_reg[5] == $past(coreInfinity))
      else $error("infinity flag not updated");

   chk_fail_addr: assert property (@(posedge clock)
      disable iff (reset) finish && pointFail && clockEnable |=>
      flags_reg[3:0] == $past(coreFailAddr))
      else $error("failing point address not loaded");

   chk_launch_start: assert property (@(posedge clock)
      disable iff (reset) launchNow |=> busy_reg && coreStart)
      else $error("accepted launch did not start the engine");
endmodule
`default_nettype wire

// file: rtl/pke_pkg.sv
`default_nettype none
package pke_pkg;
   // Register byte addresses
   localparam logic [7:0] CMD_ADDR = 8'h04;
   localparam logic [7:0] LAUNCH_ADDR = 8'h08;
   localparam logic [7:0] STATUS_ADDR = 8'h0c;
   // Values after reset
   localparam logic [31:0] CMD_RESET = 32'h0000_0000;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   // Writable command bits: recalc, signs, size, field, operation
   localparam logic [31:0] CMD_WR_MASK = 32'he000_ffff;
   // Field positions
   localparam int CMD_RECALC_BIT = 31;
   localparam int CMD_SIZE_LSB = 8;
   localparam int CMD_FIELD_BIT = 7;
   localparam int LAUNCH_BIT = 0;
   localparam int STAT_BUSY_BIT = 16;
   localparam int STAT_PRIME_BIT = 12;
   localparam int STAT_NOINV_BIT = 11;
   localparam int STAT_AB_BIT = 10;
   localparam int STAT_SIG_BIT = 9;
   // Operand length codes, in 64-bit double words
   localparam logic [7:0] SIZE_MIN = 8'h02;
   localparam logic [7:0] SIZE_MAX = 8'h40;
   localparam logic [7:0] SIZE_256 = 8'h04;
   // Operation classes
   localparam logic [2:0] CLS_PRIM = 3'h0;
   localparam logic [2:0] CLS_RSA = 3'h1;
   localparam logic [2:0] CLS_ECC = 3'h2;
   localparam logic [2:0] CLS_ECDSA = 3'h3;
   // Low codes with status side effects, and code validity limits
   localparam logic [3:0] PRIM_INV_ODD = 4'h6;
   localparam logic [3:0] PRIM_INV_EVEN = 4'h9;
   localparam logic [3:0] PRIM_MUL = 4'h8;
   localparam logic [3:0] PRIM_LAST = 4'ha;
   localparam logic [3:0] RSA_KEYGEN = 4'h1;
   localparam logic [3:0] RSA_LAST = 4'ha;
   localparam logic [3:0] RSA_SRP = 4'hc;
   localparam logic [3:0] DSA_SIGN = 4'h9;
   localparam logic [3:0] DSA_VERIFY = 4'ha;
   localparam logic [3:0] ECC_CHK_AB = 4'h3;
   localparam logic [3:0] ECC_CHK_N = 4'h4;
   localparam logic [3:0] ECC_CHK_PAIR = 4'h5;
   localparam logic [3:0] ECC_ON_CURVE = 4'h6;
   localparam logic [3:0] ECC_RESERVED = 4'h7;
   localparam logic [3:0] ECC_ED_FIRST = 4'h9;
   localparam logic [3:0] ECC_ED_VALID = 4'hb;
   localparam logic [3:0] ECC_LAST = 4'hc;
   localparam logic [3:0] ECDSA_VERIFY = 4'h1;
   localparam logic [3:0] ECDSA_LAST = 4'h5;
   // Engine sequencer states
   typedef enum logic [1:0] {
      PKE_IDLE = 2'b01,
      PKE_RUN = 2'b10
   } pke_state_t;
endpackage
`default_nettype wire

// file: tb/public_key_engine_command_status_tb_top.sv
`default_nettype none
module public_key_engine_command_status_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, coreStart, coreField, coreRecalc;
   logic [6:0] coreOpcode, capOp;
   logic [7:0] coreSize, capSize;
   logic capField, capRecalc;
   logic clkEn = 1'b1;
   logic [3:0] roExp = 4'h0;
   logic coreDone = 1'b0, coreR2Done = 1'b0;
   logic [7:0] res = 8'h00;
   logic [3:0] failAddr = 4'h0;
   int bad_count = 0, samples_checked = 0, startCount = 0;
   logic [6:0] opT[14] = '{7'h06, 7'h09, 7'h11, 7'h23, 7'h30, 7'h31, 7'h19,
      7'h1a, 7'h2b, 7'h24, 7'h25, 7'h22, 7'h26, 7'h2c};
   int idxT[14] = '{6, 6, 7, 5, 4, 4, 4, 4, 4, 3, 2, 1, 0, 0};
   logic [15:0] badT[11] = '{16'h0400, 16'h0407, 16'h040b, 16'h0488,
      16'h041b, 16'h0427, 16'h0436, 16'h0440, 16'h0470, 16'h0101, 16'h4101};

   pke_command_status i_pke_command_status (
      .clock(clock), .reset(reset), .clockEnable(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .coreStart(coreStart), .coreOpcode(coreOpcode), .coreField(coreField),
      .coreSize(coreSize), .coreRecalc(coreRecalc), .coreDone(coreDone),
      .coreR2Done(coreR2Done), .coreComposite(res[7]),
      .coreNoInverse(res[6]), .coreAbBad(res[5]), .coreSigBad(res[4]),
      .coreNBad(res[3]), .corePairBad(res[2]), .coreInfinity(res[1]),
      .coreOffCurve(res[0]), .coreFailAddr(failAddr)
   );

   // Free-running clock, 4 ns period
   always #2 clock = ~clock;

   // Count start pulses and keep the command they carried
   always @(posedge clock) begin
      if (coreStart === 1'b1) begin
         startCount++;
         capSize = coreSize;
         capOp = coreOpcode;
         capField = coreField;
         capRecalc = coreRecalc;
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task finish_test();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // One APB transfer; holds the request until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic xe);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      r = prdata;
      check(pslverr, xe, "slave error");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Status word expected: held result flags, then one op's point flags
   function automatic logic [31:0] expStat(input logic [3:0] ro,
      input logic [7:0] v, input logic [3:0] fa);
      logic [31:0] e;
      e = 32'h0;
      e[12:9] = ro;
      e[7:4] = v[3:0];
      if (v[3:0] != 4'h0) e[3:0] = fa;
      return e;
   endfunction

   // Operand length: boundaries and random first, class sizes later
   function automatic logic [7:0] pickSize(input logic [6:0] op,
      input int k, input int i);
      logic [7:0] eccT[3];
      eccT = '{8'h04, 8'h06, 8'h0a};
      if (k == 0 && i == 0) return pke_pkg::SIZE_MIN;
      if (k == 0 && i == 1) return pke_pkg::SIZE_MAX;
      if (k == 1 && op[6:4] == 3'h1) begin
         return 8'(8'h10 << ($urandom % 3));
      end
      if (k == 1 && op[6:4] != 3'h0) begin
         return eccT[$urandom % 3];
      end
      return 8'(8'h02 + $urandom % 63);
   endfunction

   task runop(input logic [6:0] op, input logic [7:0] sz, input int idx,
      input logic v);
      logic fld;
      logic rc;
      logic [3:0] fa;
      int n0;
      fld = ($urandom % 2 == 1) && (op != 7'h09);
      rc = 1'($urandom);
      fa = 4'($urandom);
      apb(1'b1, pke_pkg::STATUS_ADDR, 32'h0, 1'b0);
      apb(1'b1, pke_pkg::CMD_ADDR, {rc, 15'h0, sz, fld, op}, 1'b0);
      n0 = startCount;
      apb(1'b1, pke_pkg::LAUNCH_ADDR, 32'h1, 1'b0);
      apb(1'b0, pke_pkg::STATUS_ADDR, 32'h0, 1'b0);
      check(r[16], 1'b1, "busy while running");
      apb(1'b1, pke_pkg::LAUNCH_ADDR, 32'h1, 1'b0);
      @(posedge clock);
      res <= 8'(v) << idx;
      failAddr <= fa;
      coreDone <= 1'b1;
      @(posedge clock);
      coreDone <= 1'b0;
      res <= 8'($urandom);
      if (idx >= 4) roExp[idx - 4] = v;
      apb(1'b0, pke_pkg::STATUS_ADDR, 32'h0, 1'b0);
      check(r, expStat(roExp, 8'(v) << idx, fa), "status flags");
      apb(1'b0, pke_pkg::LAUNCH_ADDR, 32'h0, 1'b0);
      check(r, 32'h0, "launch cleared");
      check(startCount - n0, 1, "start count");
      check({capRecalc, capSize, capField, capOp},
         {rc, sz, fld & (op[6:4] != 3'h1), op}, "captured command");
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      finish_test();
   end

   initial begin
      logic [31:0] d;
      int n0;
      void'($urandom(32'hc651));
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      // Reset values, read-only bits and unmapped places
      apb(1'b0, pke_pkg::CMD_ADDR, 32'h0, 1'b0);
      check(r, pke_pkg::CMD_RESET, "command reset");
      apb(1'b1, pke_pkg::STATUS_ADDR, 32'hffff_ffff, 1'b0);
      apb(1'b0, pke_pkg::STATUS_ADDR, 32'h0, 1'b0);
      check(r, 32'h0000_00ff, "status access");
      apb(1'b1, 8'h10, 32'h1, 1'b1);
      apb(1'b0, 8'h00, 32'h0, 1'b1);
      check(r, 32'h0, "unmapped read");
      $display("test registers done");
      // Command write mask and recompute bit
      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? 32'hffff_ffff : $urandom;
         apb(1'b1, pke_pkg::CMD_ADDR, d, 1'b0);
         apb(1'b0, pke_pkg::CMD_ADDR, 32'h0, 1'b0);
         check(r, d & pke_pkg::CMD_WR_MASK, "command mask");
      end
      apb(1'b1, pke_pkg::CMD_ADDR, 32'h8000_0400, 1'b0);
      // Engine clear frozen by a low clock enable, then taken
      for (int i = 0; i < 2; i++) begin
         @(posedge clock);
         clkEn <= (i == 1);
         coreR2Done <= 1'b1;
         @(posedge clock);
         clkEn <= 1'b1;
         coreR2Done <= 1'b0;
         apb(1'b0, pke_pkg::CMD_ADDR, 32'h0, 1'b0);
         check(r, (i == 0) ? 32'h8000_0400 : 32'h0000_0400,
            "recompute cleared");
      end
      $display("test command done");
      // Refused launches
      for (int i = 0; i < 11; i++) begin
         apb(1'b1, pke_pkg::CMD_ADDR, {16'h0, badT[i]}, 1'b0);
         n0 = startCount;
         apb(1'b1, pke_pkg::LAUNCH_ADDR, 32'h1, 1'b0);
         apb(1'b0, pke_pkg::STATUS_ADDR, 32'h0, 1'b0);
         check(r[16], 1'b0, "refused busy");
         check(startCount - n0, 0, "refused start");
      end
      $display("test refusal done");
      // Every flagged operation, boundary lengths first
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 14; i++) begin
            runop(opT[i], pickSize(opT[i], k, i), idxT[i],
               (k == 0) ? 1'b1 : 1'($urandom));
         end
      end
      $display("test operations done");
      finish_test();
   end
endmodule
`default_nettype wire
